// File: rtl/fvs_params.svh
// constants of the flash verify command sequencer
// assumes a 64-bit flash word with one ecc byte and banks of 256KB
`ifndef FVS_PARAMS_SVH
`define FVS_PARAMS_SVH
`define FVS_EXEC_GO 32'h0000_0001
`define FVS_DATA_ONES 32'hFFFF_FFFF
`define FVS_PROT_SET 32'hFFFF_FFFF
`define FVS_BYTEN_CLR 9'h000
`define FVS_BYTEN_ALL 9'h1FF
`define FVS_REGION_MASK 32'hFFF0_0000
`define FVS_NONMAIN_BASE 32'h41C0_0000
`define FVS_DATA_BASE 32'h41D0_0000
`define FVS_REGION_MAIN 3'h1
`define FVS_REGION_NONMAIN 3'h2
`define FVS_REGION_DATA 3'h4
`define FVS_BANK_ONE 5'h01
`define FVS_BANK_LSB 18
`define FVS_BANK_MSB 20
`define FVS_WADDR_LSB 3
`define FVS_WADDR_MSB 17
`define FVS_ECC_BYTE 8
`define FVS_WORDS_1 16'd1
`define FVS_WORDS_2 16'd2
`define FVS_WORDS_4 16'd4
`define FVS_WORDS_8 16'd8
`define FVS_WORDS_SECTOR 16'd128
`define FVS_WORDS_BANK 16'd32768
`endif

// File: rtl/fvs_pkg.sv
// types of the flash verify command sequencer
// assumes fvs_params.svh is included by the design files
package fvs_pkg;
  typedef enum logic [2:0] {
    FVS_CMD_NOOP = 3'b000,
    FVS_CMD_PROGRAM = 3'b001,
    FVS_CMD_ERASE = 3'b010,
    FVS_CMD_COMPARE_READ_OP = 3'b011,
    FVS_CMD_ERASED_CHECK_OP = 3'b100
  } fvs_cmd_e;
  typedef enum logic [2:0] {
    FVS_SIZE_ONEWORD = 3'b000,
    FVS_SIZE_TWOWORD = 3'b001,
    FVS_SIZE_FOURWORD = 3'b010,
    FVS_SIZE_EIGHTWORD = 3'b011,
    FVS_SIZE_SECTOR = 3'b100,
    FVS_SIZE_BANK = 3'b101
  } fvs_size_e;
  typedef enum logic [1:0] {
    FVS_ST_IDLE = 2'b00,
    FVS_ST_ISSUE = 2'b01,
    FVS_ST_WAIT = 2'b10
  } fvs_state_e;
endpackage : fvs_pkg

// File: rtl/fvs_ecc_gen.sv
// ecc byte generator for one 64-bit flash word
// assumes a purely combinational use inside the sequencer
`timescale 1ns/1ps
module fvs_ecc_gen (
  input wire logic [63:0] data_in,
  output logic [7:0] ecc_out
);
  always_comb
  begin
    ecc_out = 8'h00;
    for (int j = 0; j < 64; j++)
    begin
      for (int i = 0; i < 6; i++)
      begin
        if (((j >> i) & 1) == 1)
        begin
          ecc_out[i] = ecc_out[i] ^ data_in[j];
        end
      end
      ecc_out[6] = ecc_out[6] ^ data_in[j];
      if ((j & 1) == 0)
      begin
        ecc_out[7] = ecc_out[7] ^ data_in[j];
      end
    end
  end
endmodule : fvs_ecc_gen

// File: rtl/fvs_sequencer.sv
// flash verify command sequencer: command regs, translation, status
// assumes a flash array that answers each word request with resp_valid
// Behaviour
// - ecc override compares software ecc, else generated
// - translate address, expose in status address
// - zero byte enable excludes byte from compare
// - writing one to execute starts command
// - running set at start unless protect refuses it, done at end
// - pass updated together with done
// - read mismatch sets verify failure
// - completion protects, fills data ones, clears enables
// - blank check covers eight bytes plus ecc
// - non-erased location sets verify failure
// - status address tracks and keeps last address
// - pulse count reports applied program/erase pulses
// - override uses software bank, region, address
// - single event publisher, no subscribers, static route
// - event index zero signals operation completed
// - protected program/erase terminates with protect failure
`timescale 1ns/1ps
`include "fvs_params.svh"
module fvs_sequencer (
  input wire logic clk_sys_in,
  input wire logic resetn_in,
  input wire fvs_pkg::fvs_cmd_e command_type_in,
  input wire fvs_pkg::fvs_size_e command_size_in,
  input wire logic ecc_generation_override_in,
  input wire logic translation_override_bit_in,
  input wire logic [4:0] bank_select_field_in,
  input wire logic [2:0] region_select_field_in,
  input wire logic [31:0] command_target_address_in,
  input wire logic [1:0] data_wr_in,
  input wire logic [31:0] data_wdata_in,
  input wire logic byte_enable_wr_in,
  input wire logic [8:0] byte_enable_wdata_in,
  input wire logic ecc_wr_in,
  input wire logic [7:0] ecc_wdata_in,
  input wire logic [2:0] protect_wr_in,
  input wire logic [31:0] protect_wdata_in,
  input wire logic execute_trigger_wr_in,
  input wire logic [31:0] execute_trigger_wdata_in,
  input wire logic protect_hit_in,
  input wire logic flash_resp_valid_in,
  input wire logic [63:0] flash_rdata_in,
  input wire logic [7:0] flash_recc_in,
  input wire logic flash_blank_in,
  input wire logic flash_pass_in,
  input wire logic flash_pulse_in,
  output logic flash_req_out,
  output fvs_pkg::fvs_cmd_e flash_op_out,
  output logic [8:0] flash_check_mask_out,
  output logic [4:0] status_bank_out,
  output logic [2:0] status_region_out,
  output logic [14:0] status_word_addr_out,
  output logic op_running_flag_out,
  output logic op_finished_flag_out,
  output logic op_success_flag_out,
  output logic verify_failure_flag_out,
  output logic protect_failure_flag_out,
  output logic [15:0] pulse_count_reg_out,
  output logic [31:0] compare_data_word0_out,
  output logic [31:0] compare_data_word1_out,
  output logic [8:0] byte_enable_mask_out,
  output logic [31:0] protect_a_out,
  output logic [31:0] protect_b_out,
  output logic [31:0] protect_c_out,
  output logic op_done_event_out
);
  import fvs_pkg::*;

  typedef struct packed {
    fvs_state_e st;
    fvs_cmd_e cmd;
    logic [15:0] words_left;
    logic [4:0] bank;
    logic [2:0] region;
    logic [14:0] waddr;
    logic ecc_ovr;
    logic [7:0] ecc_sw;
    logic [31:0] data0;
    logic [31:0] data1;
    logic [8:0] byten;
    logic [31:0] prot_a;
    logic [31:0] prot_b;
    logic [31:0] prot_c;
    logic running;
    logic done;
    logic pass;
    logic fail_verify;
    logic fail_prot;
    logic [15:0] pcnt;
    logic event_pulse;
    logic req;
    logic [8:0] mask;
  } fvs_seq_s;

  fvs_seq_s r;
  fvs_seq_s next_r;
  logic [7:0] gen_ecc;
  logic start;
  logic mismatch;
  logic [7:0] exp_ecc;
  logic [63:0] cmp_word;

  fvs_ecc_gen u_ecc (
    .data_in(cmp_word),
    .ecc_out(gen_ecc)
  );

  // a running command owns the trigger; late writes are dropped
  assign start = execute_trigger_wr_in && (execute_trigger_wdata_in == `FVS_EXEC_GO)
    && !r.running;
  assign exp_ecc = r.ecc_ovr ? r.ecc_sw : gen_ecc;
  assign cmp_word = {r.data1, r.data0};

  always_comb
  begin
    mismatch = 1'b0;
    for (int b = 0; b < 8; b++)
    begin
      if (r.byten[b] && (flash_rdata_in[8*b +: 8] != cmp_word[8*b +: 8]))
      begin
        mismatch = 1'b1;
      end
    end
    if (r.byten[`FVS_ECC_BYTE] && (flash_recc_in != exp_ecc))
    begin
      mismatch = 1'b1;
    end
  end

  always_comb
  begin
    next_r = r;
    next_r.event_pulse = 1'b0;
    next_r.req = 1'b0;
    if (data_wr_in[0])
    begin
      next_r.data0 = data_wdata_in;
    end
    if (data_wr_in[1])
    begin
      next_r.data1 = data_wdata_in;
    end
    if (byte_enable_wr_in)
    begin
      next_r.byten = byte_enable_wdata_in;
    end
    if (ecc_wr_in)
    begin
      next_r.ecc_sw = ecc_wdata_in;
    end
    if (protect_wr_in[0])
    begin
      next_r.prot_a = protect_wdata_in;
    end
    if (protect_wr_in[1])
    begin
      next_r.prot_b = protect_wdata_in;
    end
    if (protect_wr_in[2])
    begin
      next_r.prot_c = protect_wdata_in;
    end
    if (r.running && flash_pulse_in)
    begin
      next_r.pcnt = r.pcnt + 16'h0001;
    end
    unique case (r.st)
      FVS_ST_IDLE:
      begin
        if (start)
        begin
          next_r.cmd = command_type_in;
          next_r.ecc_ovr = ecc_generation_override_in;
          next_r.running = 1'b1;
          next_r.done = 1'b0;
          next_r.pass = 1'b0;
          next_r.fail_verify = 1'b0;
          next_r.fail_prot = 1'b0;
          next_r.pcnt = 16'h0000;
          next_r.st = FVS_ST_ISSUE;
          next_r.waddr = command_target_address_in[`FVS_WADDR_MSB:`FVS_WADDR_LSB];
          if (translation_override_bit_in)
          begin
            next_r.bank = bank_select_field_in;
            next_r.region = region_select_field_in;
          end
          else
          begin
            next_r.bank = `FVS_BANK_ONE <<
              command_target_address_in[`FVS_BANK_MSB:`FVS_BANK_LSB];
            if ((command_target_address_in & `FVS_REGION_MASK) == `FVS_NONMAIN_BASE)
            begin
              next_r.region = `FVS_REGION_NONMAIN;
            end
            else if ((command_target_address_in & `FVS_REGION_MASK) == `FVS_DATA_BASE)
            begin
              next_r.region = `FVS_REGION_DATA;
            end
            else
            begin
              next_r.region = `FVS_REGION_MAIN;
            end
          end
          // blank check is always one word, whatever the size field says
          if (command_type_in == FVS_CMD_ERASED_CHECK_OP)
          begin
            next_r.words_left = `FVS_WORDS_1;
          end
          else
          begin
            unique case (command_size_in)
              FVS_SIZE_ONEWORD: next_r.words_left = `FVS_WORDS_1;
              FVS_SIZE_TWOWORD: next_r.words_left = `FVS_WORDS_2;
              FVS_SIZE_FOURWORD: next_r.words_left = `FVS_WORDS_4;
              FVS_SIZE_EIGHTWORD: next_r.words_left = `FVS_WORDS_8;
              FVS_SIZE_SECTOR: next_r.words_left = `FVS_WORDS_SECTOR;
              FVS_SIZE_BANK: next_r.words_left = `FVS_WORDS_BANK;
              default: next_r.words_left = `FVS_WORDS_1;
            endcase
          end
          if (((command_type_in == FVS_CMD_PROGRAM) || (command_type_in == FVS_CMD_ERASE))
            && protect_hit_in)
          begin
            next_r.fail_prot = 1'b1;
            next_r.st = FVS_ST_IDLE;
          end
        end
      end
      FVS_ST_ISSUE:
      begin
        next_r.req = 1'b1;
        next_r.mask = (r.cmd == FVS_CMD_ERASED_CHECK_OP) ? `FVS_BYTEN_ALL : r.byten;
        next_r.st = FVS_ST_WAIT;
      end
      FVS_ST_WAIT:
      begin
        if (flash_resp_valid_in)
        begin
          if ((r.cmd == FVS_CMD_COMPARE_READ_OP) && mismatch)
          begin
            next_r.fail_verify = 1'b1;
          end
          if ((r.cmd == FVS_CMD_ERASED_CHECK_OP) && !flash_blank_in)
          begin
            next_r.fail_verify = 1'b1;
          end
          if (((r.cmd == FVS_CMD_PROGRAM) || (r.cmd == FVS_CMD_ERASE)) && !flash_pass_in)
          begin
            next_r.fail_verify = 1'b1;
          end
          if (r.words_left == `FVS_WORDS_1)
          begin
            next_r.st = FVS_ST_IDLE;
          end
          else
          begin
            // address advances; the last word touched stays visible
            next_r.words_left = r.words_left - 16'h0001;
            next_r.waddr = r.waddr + 15'h0001;
            next_r.st = FVS_ST_ISSUE;
          end
        end
      end
      default:
      begin
        next_r.st = FVS_ST_IDLE;
      end
    endcase
    // finish: hardware fill wins over a software write in the same cycle
    if (r.running && (next_r.st == FVS_ST_IDLE) || (start && next_r.fail_prot))
    begin
      next_r.running = 1'b0;
      next_r.done = 1'b1;
      next_r.pass = !(next_r.fail_verify || next_r.fail_prot);
      next_r.event_pulse = 1'b1;
      next_r.data0 = `FVS_DATA_ONES;
      next_r.data1 = `FVS_DATA_ONES;
      next_r.byten = `FVS_BYTEN_CLR;
      next_r.prot_a = `FVS_PROT_SET;
      next_r.prot_b = `FVS_PROT_SET;
      next_r.prot_c = `FVS_PROT_SET;
    end
  end

  always_ff @(posedge clk_sys_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      r <= '0;
      r.st <= FVS_ST_IDLE;
      r.data0 <= `FVS_DATA_ONES;
      r.data1 <= `FVS_DATA_ONES;
      r.prot_a <= `FVS_PROT_SET;
      r.prot_b <= `FVS_PROT_SET;
      r.prot_c <= `FVS_PROT_SET;
    end
    else
    begin
      r <= next_r;
    end
  end

  assign flash_req_out = r.req;
  assign flash_op_out = r.cmd;
  assign flash_check_mask_out = r.mask;
  assign status_bank_out = r.bank;
  assign status_region_out = r.region;
  assign status_word_addr_out = r.waddr;
  assign op_running_flag_out = r.running;
  assign op_finished_flag_out = r.done;
  assign op_success_flag_out = r.pass;
  assign verify_failure_flag_out = r.fail_verify;
  assign protect_failure_flag_out = r.fail_prot;
  assign pulse_count_reg_out = r.pcnt;
  assign compare_data_word0_out = r.data0;
  assign compare_data_word1_out = r.data1;
  assign byte_enable_mask_out = r.byten;
  assign protect_a_out = r.prot_a;
  assign protect_b_out = r.prot_b;
  assign protect_c_out = r.prot_c;
  assign op_done_event_out = r.event_pulse;

  sequence s_start;
    start && !(protect_hit_in && ((command_type_in == FVS_CMD_PROGRAM)
      || (command_type_in == FVS_CMD_ERASE)));
  endsequence
  // the event, not a rise of done: a refused protected start leaves done high
  sequence s_finish;
    r.event_pulse;
  endsequence

  property p_start_running;
    @(posedge clk_sys_in) disable iff (!resetn_in)
      s_start |=> r.running && !r.done ##1 flash_req_out;
  endproperty
  a_start_running: assert property (p_start_running) else $error("start not taken");

  property p_ignore_exec;
    @(posedge clk_sys_in) disable iff (!resetn_in)
      r.running && execute_trigger_wr_in && !flash_resp_valid_in
        |=> r.running && $stable(r.cmd);
  endproperty
  a_ignore_exec: assert property (p_ignore_exec) else $error("exec not ignored");

  property p_pass;
    @(posedge clk_sys_in) disable iff (!resetn_in)
      s_finish |-> r.pass == !(r.fail_verify || r.fail_prot) && !r.running;
  endproperty
  a_pass: assert property (p_pass) else $error("pass wrong at done");

  property p_fill;
    @(posedge clk_sys_in) disable iff (!resetn_in)
      s_finish |-> r.data0 == `FVS_DATA_ONES && r.byten == `FVS_BYTEN_CLR
        && r.prot_c == `FVS_PROT_SET;
  endproperty
  a_fill: assert property (p_fill) else $error("completion fill missing");

  property p_event;
    @(posedge clk_sys_in) disable iff (!resetn_in)
      op_done_event_out |-> r.done && !r.running ##1 (!op_done_event_out || r.fail_prot);
  endproperty
  a_event: assert property (p_event) else $error("event without done");

  property p_blank_mask;
    @(posedge clk_sys_in) disable iff (!resetn_in)
      flash_req_out && (r.cmd == FVS_CMD_ERASED_CHECK_OP) |-> flash_check_mask_out == `FVS_BYTEN_ALL;
  endproperty
  a_blank_mask: assert property (p_blank_mask) else $error("blank mask short");

  property p_override;
    @(posedge clk_sys_in) disable iff (!resetn_in)
      (s_start and translation_override_bit_in) |=> r.bank == $past(bank_select_field_in);
  endproperty
  a_override: assert property (p_override) else $error("override bank ignored");

  property p_verify_fail;
    @(posedge clk_sys_in) disable iff (!resetn_in)
      (r.st == FVS_ST_WAIT) && flash_resp_valid_in && mismatch
        && (r.cmd == FVS_CMD_COMPARE_READ_OP)
        |=> r.fail_verify ##1 (r.fail_verify || $past(start));
  endproperty
  a_verify_fail: assert property (p_verify_fail) else $error("mismatch not flagged");

  property p_blank_fail;
    @(posedge clk_sys_in) disable iff (!resetn_in)
      (r.st == FVS_ST_WAIT) && flash_resp_valid_in && !flash_blank_in
        && (r.cmd == FVS_CMD_ERASED_CHECK_OP) |=> r.fail_verify && r.done && !r.pass;
  endproperty
  a_blank_fail: assert property (p_blank_fail) else $error("not blank not flagged");

  property p_prot;
    @(posedge clk_sys_in) disable iff (!resetn_in)
      start && protect_hit_in && (command_type_in == FVS_CMD_ERASE)
        |=> r.done && r.fail_prot && !r.running;
  endproperty
  a_prot: assert property (p_prot) else $error("protect failure missing");

  property p_pcnt;
    @(posedge clk_sys_in) disable iff (!resetn_in)
      r.running && flash_pulse_in |=> r.pcnt == $past(r.pcnt) + 16'h0001;
  endproperty
  a_pcnt: assert property (p_pcnt) else $error("pulse count stuck");
endmodule : fvs_sequencer

// File: bench/fvs_flash_model.sv
// flash bank model: answers each word request after a set latency
// assumes one request at a time, one-cycle request pulses
`timescale 1ns/1ps
module fvs_flash_model (
  input wire logic clk_sys_in,
  input wire logic resetn_in,
  input wire logic req_in,
  input wire fvs_pkg::fvs_cmd_e op_in,
  input wire logic [7:0] latency_in,
  input wire logic [63:0] word_in,
  input wire logic [7:0] ecc_in,
  input wire logic blank_in,
  input wire logic pass_in,
  output logic resp_valid_out,
  output logic [63:0] rdata_out,
  output logic [7:0] recc_out,
  output logic blank_out,
  output logic pass_out,
  output logic pulse_out
);
  import fvs_pkg::*;
  logic busy;
  logic pe;
  logic [7:0] cnt;
  always_ff @(posedge clk_sys_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      {busy, pe, cnt, resp_valid_out, pulse_out} <= '0;
      {rdata_out, recc_out, blank_out, pass_out} <= '0;
    end
    else
    begin
      resp_valid_out <= 1'b0;
      pulse_out <= 1'b0;
      // no pull on these lines: toggle so a stale value never matches
      rdata_out <= ~rdata_out;
      recc_out <= ~recc_out;
      blank_out <= ~blank_out;
      pass_out <= ~pass_out;
      if (req_in)
      begin
        busy <= 1'b1;
        cnt <= latency_in;
        pe <= (op_in == FVS_CMD_PROGRAM) || (op_in == FVS_CMD_ERASE);
      end
      else if (busy && cnt != 8'h00)
      begin
        cnt <= cnt - 8'h01;
        pulse_out <= pe;
      end
      else if (busy)
      begin
        busy <= 1'b0;
        resp_valid_out <= 1'b1;
        rdata_out <= word_in;
        recc_out <= ecc_in;
        blank_out <= blank_in;
        pass_out <= pass_in;
      end
    end
  end
endmodule : fvs_flash_model

// File: bench/fvs_sequencer_tb.sv
// self-checking bench of the flash verify command sequencer
// assumes the flash model answers every request it receives
`timescale 1ns/1ps
`include "fvs_params.svh"
module fvs_sequencer_tb;
  import fvs_pkg::*;
  logic clk_sys_in, resetn_in, ecc_ovr, xo, be_wr, ecc_wr, ex_wr, prot_hit, req, rv;
  logic blank, pass, pulse, evt, running, finished, success, vfail, pfail, m_blank, m_pass;
  fvs_cmd_e cmd, fop;
  fvs_size_e size;
  logic [1:0] data_wr;
  logic [2:0] prot_wr, rsel, s_region;
  logic [4:0] bsel, s_bank;
  logic [7:0] ecc_wdata, recc, lat, m_ecc;
  logic [8:0] be_wdata, fmask, bemask, last_mask;
  logic [14:0] s_waddr;
  logic [15:0] pcnt;
  logic [31:0] addr, data_wdata, prot_wdata, ex_wdata, d0, d1, pa, pb, pc;
  logic [63:0] rdata, m_data;
  int fails, total_checks, reqs, evts;
  localparam logic [63:0] D = 64'h0123_4567_89AB_CDEF;
  fvs_sequencer fvs_sequencer_inst (.clk_sys_in(clk_sys_in), .resetn_in(resetn_in),
    .command_type_in(cmd), .command_size_in(size), .ecc_generation_override_in(ecc_ovr),
    .translation_override_bit_in(xo), .bank_select_field_in(bsel),
    .region_select_field_in(rsel), .command_target_address_in(addr), .data_wr_in(data_wr),
    .data_wdata_in(data_wdata), .byte_enable_wr_in(be_wr), .byte_enable_wdata_in(be_wdata),
    .ecc_wr_in(ecc_wr), .ecc_wdata_in(ecc_wdata), .protect_wr_in(prot_wr),
    .protect_wdata_in(prot_wdata), .execute_trigger_wr_in(ex_wr),
    .execute_trigger_wdata_in(ex_wdata), .protect_hit_in(prot_hit), .flash_resp_valid_in(rv),
    .flash_rdata_in(rdata), .flash_recc_in(recc), .flash_blank_in(blank),
    .flash_pass_in(pass), .flash_pulse_in(pulse), .flash_req_out(req), .flash_op_out(fop),
    .flash_check_mask_out(fmask), .status_bank_out(s_bank), .status_region_out(s_region),
    .status_word_addr_out(s_waddr), .op_running_flag_out(running),
    .op_finished_flag_out(finished), .op_success_flag_out(success),
    .verify_failure_flag_out(vfail), .protect_failure_flag_out(pfail),
    .pulse_count_reg_out(pcnt), .compare_data_word0_out(d0), .compare_data_word1_out(d1),
    .byte_enable_mask_out(bemask), .protect_a_out(pa), .protect_b_out(pb),
    .protect_c_out(pc), .op_done_event_out(evt));
  fvs_flash_model fvs_flash_model_inst (.clk_sys_in(clk_sys_in), .resetn_in(resetn_in),
    .req_in(req), .op_in(fop), .latency_in(lat), .word_in(m_data), .ecc_in(m_ecc),
    .blank_in(m_blank), .pass_in(m_pass), .resp_valid_out(rv), .rdata_out(rdata),
    .recc_out(recc), .blank_out(blank), .pass_out(pass), .pulse_out(pulse));
  initial
  begin
    clk_sys_in = 1'b0;
    forever #10 clk_sys_in = ~clk_sys_in;
  end
  always @(posedge clk_sys_in)
  begin
    if (req)
      last_mask <= fmask;
    reqs += int'(req);
    evts += int'(evt);
  end
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      fails++;
      $display("Error t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask : chk
  task automatic stop_test();
    if (fails == 0 && total_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : stop_test
  // writes every register, fires execute, waits for done, checks the aftermath
  task automatic run(input fvs_cmd_e c, input fvs_size_e s, input logic [31:0] a,
      input logic [63:0] w, input logic [8:0] be, input logic [7:0] e, input logic poke);
    int n;
    @(posedge clk_sys_in);
    cmd <= c;
    size <= s;
    addr <= a;
    prot_wr <= 3'b111;
    data_wr <= 2'b01;
    data_wdata <= w[31:0];
    be_wr <= 1'b1;
    be_wdata <= be;
    ecc_wr <= 1'b1;
    ecc_wdata <= e;
    @(posedge clk_sys_in);
    prot_wr <= 3'b000;
    data_wr <= 2'b10;
    data_wdata <= w[63:32];
    be_wr <= 1'b0;
    ecc_wr <= 1'b0;
    @(posedge clk_sys_in);
    data_wr <= 2'b00;
    ex_wr <= 1'b1;
    ex_wdata <= `FVS_EXEC_GO;
    @(posedge clk_sys_in);
    ex_wr <= poke;
    #1;
    reqs = 0;
    evts = 0;
    if (!prot_hit)
      chk(running, 1'b1);
    @(posedge clk_sys_in);
    ex_wr <= 1'b0;
    // a sector erase takes about seven cycles a word
    for (n = 0; n < 2000 && finished !== 1'b1; n++)
      @(posedge clk_sys_in);
    repeat (2) @(posedge clk_sys_in);
    #1;
    chk({running, finished}, 2'b01);
    chk({d0, d1}, {`FVS_DATA_ONES, `FVS_DATA_ONES});
    chk({pa, pb, pc}, {`FVS_PROT_SET, `FVS_PROT_SET, `FVS_PROT_SET});
    chk(bemask, `FVS_BYTEN_CLR);
    chk(evts, 1);
  endtask : run
  // n below zero skips the request count, left open for erase sizes
  task automatic outcome(input logic s, input logic v, input logic p, input int n);
    chk({success, vfail}, {s, v});
    chk(pfail, p);
    if (n >= 0)
      chk(reqs, n);
  endtask : outcome
  task automatic bad_exec();
    @(posedge clk_sys_in);
    ex_wr <= 1'b1;
    ex_wdata <= 32'h0000_0002;
    @(posedge clk_sys_in);
    ex_wr <= 1'b0;
    repeat (3) @(posedge clk_sys_in);
    #1;
    chk({running, finished}, 2'b01);
  endtask : bad_exec
  initial
  begin
    #200000;
    fails++;
    stop_test();
  end
  initial
  begin
    {resetn_in, ecc_ovr, xo, be_wr, ecc_wr, ex_wr, prot_hit, data_wr, prot_wr} = '0;
    {addr, data_wdata, prot_wdata, ex_wdata, be_wdata, ecc_wdata} = '0;
    {fails, total_checks, reqs, evts} = '0;
    cmd = FVS_CMD_NOOP;
    size = FVS_SIZE_ONEWORD;
    bsel = 5'h01;
    rsel = 3'h1;
    lat = 8'h02;
    m_data = D;
    m_ecc = 8'h5A;
    m_blank = 1'b1;
    m_pass = 1'b1;
    repeat (4) @(posedge clk_sys_in);
    #1;
    chk({running, finished, pcnt}, 18'h0);
    chk({d0, bemask}, {`FVS_DATA_ONES, `FVS_BYTEN_CLR});
    @(posedge clk_sys_in);
    resetn_in <= 1'b1;
    ecc_ovr <= 1'b1;
    run(FVS_CMD_COMPARE_READ_OP, FVS_SIZE_ONEWORD, 32'h0001_2348, D, 9'h1FF, 8'h5A, 1'b0);
    outcome(1'b1, 1'b0, 1'b0, 1);
    chk({s_bank, s_region, s_waddr}, {5'h01, 3'h1, 15'h2469});
    chk(last_mask, 9'h1FF);
    run(FVS_CMD_COMPARE_READ_OP, FVS_SIZE_ONEWORD, 32'h0001_2348, D ^ 64'h1_0000, 9'h1FF,
      8'h5A, 1'b0);
    outcome(1'b0, 1'b1, 1'b0, 1);
    run(FVS_CMD_COMPARE_READ_OP, FVS_SIZE_ONEWORD, 32'h0001_2348, D ^ 64'h1_0000, 9'h1FB,
      8'h5A, 1'b0);
    outcome(1'b1, 1'b0, 1'b0, 1);
    chk(last_mask, 9'h1FB);
    run(FVS_CMD_COMPARE_READ_OP, FVS_SIZE_ONEWORD, 32'h0001_2348, D, 9'h1FF, 8'hA5, 1'b0);
    outcome(1'b0, 1'b1, 1'b0, 1);
    ecc_ovr <= 1'b0;
    run(FVS_CMD_COMPARE_READ_OP, FVS_SIZE_ONEWORD, 32'h0001_2348, D, 9'h0FF, 8'hA5, 1'b0);
    outcome(1'b1, 1'b0, 1'b0, 1);
    // parity of an all-zero word is zero; the wrong software ecc must be ignored
    m_data <= 64'h0;
    m_ecc <= 8'h00;
    run(FVS_CMD_COMPARE_READ_OP, FVS_SIZE_ONEWORD, 32'h0001_2348, 64'h0, 9'h1FF, 8'hA5, 1'b0);
    outcome(1'b1, 1'b0, 1'b0, 1);
    m_data <= D;
    m_ecc <= 8'h5A;
    lat <= 8'h05;
    run(FVS_CMD_COMPARE_READ_OP, FVS_SIZE_FOURWORD, 32'h0000_0100, D, 9'h0FF, 8'h00, 1'b1);
    outcome(1'b1, 1'b0, 1'b0, 4);
    chk(s_waddr, 15'h0023);
    bad_exec();
    xo <= 1'b1;
    run(FVS_CMD_ERASED_CHECK_OP, FVS_SIZE_ONEWORD, 32'h0000_0000, D, 9'h000, 8'h00,
      1'b0);
    outcome(1'b1, 1'b0, 1'b0, 1);
    chk(last_mask, `FVS_BYTEN_ALL);
    chk({s_bank, s_region, s_waddr}, {5'h01, 3'h1, 15'h0000});
    m_blank <= 1'b0;
    bsel <= 5'h04;
    rsel <= 3'h2;
    run(FVS_CMD_ERASED_CHECK_OP, FVS_SIZE_ONEWORD, 32'h0000_0018, D, 9'h000, 8'h00, 1'b0);
    outcome(1'b0, 1'b1, 1'b0, 1);
    chk({s_bank, s_region, s_waddr}, {5'h04, 3'h2, 15'h0003});
    xo <= 1'b0;
    lat <= 8'h03;
    run(FVS_CMD_ERASE, FVS_SIZE_SECTOR, 32'h0000_0400, D, 9'h000, 8'h00, 1'b0);
    outcome(1'b1, 1'b0, 1'b0, int'(`FVS_WORDS_SECTOR));
    // three pulses per word at latency three, over the whole sector
    chk(pcnt, `FVS_WORDS_SECTOR * 16'd3);
    m_pass <= 1'b0;
    run(FVS_CMD_ERASE, FVS_SIZE_SECTOR, 32'h0000_0400, D, 9'h000, 8'h00, 1'b0);
    outcome(1'b0, 1'b1, 1'b0, int'(`FVS_WORDS_SECTOR));
    prot_hit <= 1'b1;
    run(FVS_CMD_PROGRAM, FVS_SIZE_ONEWORD, 32'h0000_0400, D, 9'h1FF, 8'h00, 1'b0);
    outcome(1'b0, 1'b0, 1'b1, 0);
    stop_test();
  end
endmodule : fvs_sequencer_tb
